// file: src/dtc_pkg.sv
// Package holding register offsets, field positions and timing constants of the dual timer block.
package dtc_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 8;
    // Register offsets.
    localparam logic [7:0]  OFS_CONTROL   = 8'h88;
    localparam logic [7:0]  OFS_MODE      = 8'h89;
    localparam logic [7:0]  OFS_C0_LOW    = 8'h8A;
    localparam logic [7:0]  OFS_C1_LOW    = 8'h8B;
    localparam logic [7:0]  OFS_C0_HIGH   = 8'h8C;
    localparam logic [7:0]  OFS_C1_HIGH   = 8'h8D;
    localparam logic [7:0]  OFS_CORE_CFG  = 8'h8E;
    localparam logic [7:0]  OFS_ISR_ACK   = 8'h8F;
    localparam logic [7:0]  RESET_BYTE    = 8'h00;
    // Mode register field positions for counter 0; counter 1 sits four bits higher.
    localparam int          MF_MODE_LO    = 0;
    localparam int          MF_MODE_HI    = 1;
    localparam int          MF_FUNC       = 2;
    localparam int          MF_GATE       = 3;
    localparam int          MF_C1_OFS     = 4;
    // Control register field positions.
    localparam int          CF_RUN0       = 4;
    localparam int          CF_OVF0       = 5;
    localparam int          CF_RUN1       = 6;
    localparam int          CF_OVF1       = 7;
    // Core configuration bit: 1 selects the undivided oscillator.
    localparam int          CFG_FAST      = 0;
    // Count widths and limits.
    localparam int          PRE_BITS      = 5;
    localparam logic [4:0]  PRE_MAX       = 5'h1F;
    localparam logic [7:0]  BYTE_MAX      = 8'hFF;
    // Timer tick is one per six peripheral clocks; machine cycle matches it.
    localparam int          TICK_DIV      = 6;
    localparam logic [2:0]  TICK_LAST     = 3'(TICK_DIV - 1);
    typedef enum logic [1:0] {
        DTC_MODE0,
        DTC_MODE1,
        DTC_MODE2,
        DTC_MODE3
    } dtc_mode_t;
endpackage

// file: src/dtc_tick_gen.sv
// Peripheral clock and timer tick divider.
`timescale 1ns/1ns
`default_nettype none
module dtc_tick_gen (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic resetn,
    // Configuration.
    input  wire logic fast_mode,
    // Enables.
    output logic      periph_en,
    output logic      tick_en
);
    import dtc_pkg::*;

    logic       half_reg, half_next;
    logic [2:0] div_reg, div_next;

    // Peripheral enable is every cycle in fast mode, every other cycle otherwise; tick is one per six.
    always_comb begin
        half_next = ~half_reg;
        periph_en = fast_mode | half_reg;
        div_next  = div_reg;
        tick_en   = 1'b0;
        if (periph_en) begin
            if (div_reg == TICK_LAST) begin
                div_next = 3'h0;
                tick_en  = 1'b1;
            end else begin
                div_next = div_reg + 3'h1;
            end
        end
    end

    // Divider state registers.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            half_reg <= 1'b0;
            div_reg  <= 3'h0;
        end else begin
            half_reg <= half_next;
            div_reg  <= div_next;
        end
    end
endmodule // dtc_tick_gen
`default_nettype wire

// file: src/dtc_pin_sync.sv
// Pin synchroniser and falling edge detector sampled once per machine cycle.
`timescale 1ns/1ns
`default_nettype none
module dtc_pin_sync (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic resetn,
    // Sampling enable.
    input  wire logic tick_en,
    // Pin and results.
    input  wire logic pin,
    output logic      level,
    output logic      fall
);
    logic meta_reg, sync_reg, samp_reg, samp_next;

    // Sample once per machine cycle; a fall is a high sample followed by a low one.
    always_comb begin
        samp_next = tick_en ? sync_reg : samp_reg;
        fall      = tick_en & samp_reg & ~sync_reg;
        level     = sync_reg;
    end

    // Two-stage synchroniser and sample register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            samp_reg <= 1'b0;
        end else begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
            samp_reg <= samp_next;
        end
    end
endmodule // dtc_pin_sync
`default_nettype wire

// file: src/dtc_timer.sv
// Dual four-mode timer/counter with byte-wide register port.
// What this block does
// - Each counter keeps a low and high byte register, readable and writable.
// - Mode 0 counts thirteen bits: high byte plus low five bits.
// - Modes 0-2 count when run is set and gate off or gate pin high.
// - Mode 0 wrap from 1FFF to 0000 sets the overflow flag.
// - Peripheral clock is oscillator over two, or undivided in fast mode.
// - Mode 1 counts sixteen bits; wrap FFFF to 0000 sets overflow.
// - Mode 2 low byte overflow sets flag and reloads from high byte.
// - Mode 2 reload leaves the high byte unchanged.
// - Only counter 1 overflows feed the UART baud output.
// - Counter 1 in mode 3 halts and holds its count.
// - Counter 0 mode 3 low byte uses counter 0 controls and flag.
// - Counter 0 mode 3 high byte times, runs on counter1 run, sets counter1 flag.
// - With counter 0 in mode 3, counter 1 ignores run bit and flag.
// - Then counter 1 still honours gate control and gate pin.
// - Timer function advances once per six peripheral clocks.
// - Count pin sampled per machine cycle; high then low increments.
// - Mode register holds gate, function select and two-bit mode per counter.
// - Overflow flags clear on service entry; clearing run holds the count.
`timescale 1ns/1ns
`default_nettype none
module dtc_timer (
    // Clock and reset.
    input  wire logic                       CLK,
    input  wire logic                       RESETN,
    // Register port.
    input  wire logic [dtc_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [dtc_pkg::DATA_W-1:0] WDATA,
    input  wire logic                       WR,
    input  wire logic                       RD,
    output logic      [dtc_pkg::DATA_W-1:0] RDATA,
    // External pins.
    input  wire logic                       COUNTER0_COUNT_PIN,
    input  wire logic                       COUNTER1_COUNT_PIN,
    input  wire logic                       COUNTER0_GATE_PIN,
    input  wire logic                       COUNTER1_GATE_PIN,
    // Interrupt service entry acknowledges.
    input  wire logic                       SERVICE0_ACK,
    input  wire logic                       SERVICE1_ACK,
    // Status outputs.
    output logic                            COUNTER0_OVERFLOW,
    output logic                            COUNTER1_OVERFLOW,
    output logic                            BAUD_TICK
);
    import dtc_pkg::*;

    // Count bytes of both counters.
    logic [7:0] c0_low_reg;
    logic [7:0] c0_low_next;
    logic [7:0] c0_high_reg;
    logic [7:0] c0_high_next;
    logic [7:0] c1_low_reg;
    logic [7:0] c1_low_next;
    logic [7:0] c1_high_reg;
    logic [7:0] c1_high_next;
    // Mode, control and core configuration.
    logic [7:0] mode_reg;
    logic [7:0] mode_next;
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic       cfg_fast_reg;
    logic       cfg_fast_next;
    // Registered read data and baud pulse.
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       baud_reg;
    logic       baud_next;
    // Tick enable and synchronised pins.
    logic       tick_en;
    logic [1:0] cnt_fall;
    logic [1:0] gate_level;
    // Decoded modes.
    dtc_mode_t  mode0;
    dtc_mode_t  mode1;

    // Timing source.
    dtc_tick_gen u_tick (
        .clk       (CLK),
        .resetn    (RESETN),
        .fast_mode (cfg_fast_reg),
        .periph_en (),
        .tick_en   (tick_en)
    );

    // One synchroniser per count pin and gate pin.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pins
            dtc_pin_sync u_cnt (
                .clk     (CLK),
                .resetn  (RESETN),
                .tick_en (tick_en),
                .pin     (gi == 0 ? COUNTER0_COUNT_PIN : COUNTER1_COUNT_PIN),
                .level   (),
                .fall    (cnt_fall[gi])
            );
            dtc_pin_sync u_gate (
                .clk     (CLK),
                .resetn  (RESETN),
                .tick_en (tick_en),
                .pin     (gi == 0 ? COUNTER0_GATE_PIN : COUNTER1_GATE_PIN),
                .level   (gate_level[gi]),
                .fall    ()
            );
        end
    endgenerate

    // Mode fields decoded from the mode register.
    // The enum order matches the two-bit field, so the cast needs no table.
    assign mode0 = dtc_mode_t'(mode_reg[MF_MODE_HI:MF_MODE_LO]);
    assign mode1 = dtc_mode_t'(mode_reg[MF_C1_OFS+MF_MODE_HI:MF_C1_OFS+MF_MODE_LO]);

    // Count engine, register writes and flag handling.
    always_comb begin
        logic        ev0;
        logic        ev1;
        logic        en0;
        logic        en1;
        logic        en0h;
        logic        split;
        logic        set_ovf0;
        logic        set_ovf1;
        logic        c1_wrap;
        logic [5:0]  lo6;
        logic [8:0]  hi9;
        logic [16:0] w17;
        c0_low_next   = c0_low_reg;
        c0_high_next  = c0_high_reg;
        c1_low_next   = c1_low_reg;
        c1_high_next  = c1_high_reg;
        mode_next     = mode_reg;
        ctrl_next     = ctrl_reg;
        cfg_fast_next = cfg_fast_reg;
        set_ovf0      = 1'b0;
        set_ovf1      = 1'b0;
        c1_wrap       = 1'b0;
        lo6           = 6'h00;
        hi9           = 9'h000;
        w17           = 17'h00000;
        split         = (mode0 == DTC_MODE3);
        // Count events: internal tick in timer function, sampled fall in counter function.
        ev0  = mode_reg[MF_FUNC] ? cnt_fall[0] : tick_en;
        ev1  = mode_reg[MF_C1_OFS+MF_FUNC] ? cnt_fall[1] : tick_en;
        // Run qualified by gate control and gate pin.
        en0  = ev0 & ctrl_reg[CF_RUN0] & (~mode_reg[MF_GATE] | gate_level[0]);
        en1  = ev1 & (split | ctrl_reg[CF_RUN1])
             & (~mode_reg[MF_C1_OFS+MF_GATE] | gate_level[1]);
        en0h = tick_en & ctrl_reg[CF_RUN1];

        // Counter 0.
        if (en0) begin
            case (mode0)
                DTC_MODE0: begin
                    lo6 = {1'b0, c0_low_reg[PRE_BITS-1:0]} + 6'h01;
                    c0_low_next[PRE_BITS-1:0] = lo6[PRE_BITS-1:0];
                    if (lo6[PRE_BITS]) begin
                        hi9 = {1'b0, c0_high_reg} + 9'h001;
                        c0_high_next = hi9[7:0];
                        set_ovf0 = hi9[8];
                    end
                end
                DTC_MODE1: begin
                    w17 = {1'b0, c0_high_reg, c0_low_reg} + 17'h00001;
                    {c0_high_next, c0_low_next} = w17[15:0];
                    set_ovf0 = w17[16];
                end
                DTC_MODE2, DTC_MODE3: begin
                    if (c0_low_reg == BYTE_MAX) begin
                        c0_low_next = (mode0 == DTC_MODE2) ? c0_high_reg : RESET_BYTE;
                        set_ovf0 = 1'b1;
                    end else begin
                        c0_low_next = c0_low_reg + 8'h01;
                    end
                end
                default: c0_low_next = c0_low_reg;
            endcase
        end
        // Counter 0 high byte as a separate timer in split mode.
        // Split mode lends counter 1's run bit and flag to this byte, as counter 1 then has no use for them.
        if (split && en0h) begin
            c0_high_next = c0_high_reg + 8'h01;
            set_ovf1 = (c0_high_reg == BYTE_MAX);
        end

        // Counter 1; mode 3 freezes it.
        // In split mode counter 1 ignores its run bit so it can keep feeding the baud pulse.
        if (en1) begin
            case (mode1)
                DTC_MODE0: begin
                    lo6 = {1'b0, c1_low_reg[PRE_BITS-1:0]} + 6'h01;
                    c1_low_next[PRE_BITS-1:0] = lo6[PRE_BITS-1:0];
                    if (lo6[PRE_BITS]) begin
                        hi9 = {1'b0, c1_high_reg} + 9'h001;
                        c1_high_next = hi9[7:0];
                        c1_wrap = hi9[8];
                    end
                end
                DTC_MODE1: begin
                    w17 = {1'b0, c1_high_reg, c1_low_reg} + 17'h00001;
                    {c1_high_next, c1_low_next} = w17[15:0];
                    c1_wrap = w17[16];
                end
                DTC_MODE2: begin
                    if (c1_low_reg == BYTE_MAX) begin
                        c1_low_next = c1_high_reg;
                        c1_wrap = 1'b1;
                    end else begin
                        c1_low_next = c1_low_reg + 8'h01;
                    end
                end
                default: c1_low_next = c1_low_reg;
            endcase
        end
        // Counter 1 flag only reports counter 1 when not split.
        if (!split && c1_wrap) begin
            set_ovf1 = 1'b1;
        end

        // Software writes replace the stored value at once.
        // Coming after the count logic, a write beats a count in the same cycle.
        if (WR) begin
            case (ADDR)
                OFS_C0_LOW:   c0_low_next   = WDATA;
                OFS_C0_HIGH:  c0_high_next  = WDATA;
                OFS_C1_LOW:   c1_low_next   = WDATA;
                OFS_C1_HIGH:  c1_high_next  = WDATA;
                OFS_MODE:     mode_next     = WDATA;
                OFS_CONTROL:  ctrl_next     = WDATA;
                OFS_CORE_CFG: cfg_fast_next = WDATA[CFG_FAST];
                default:      ctrl_next     = ctrl_next;
            endcase
        end
        // Service entry clears flags; a hardware set wins.
        // Clears come first so an overflow in the acknowledge cycle is never lost.
        if (SERVICE0_ACK) begin
            ctrl_next[CF_OVF0] = 1'b0;
        end
        if (SERVICE1_ACK) begin
            ctrl_next[CF_OVF1] = 1'b0;
        end
        if (set_ovf0) begin
            ctrl_next[CF_OVF0] = 1'b1;
        end
        if (set_ovf1) begin
            ctrl_next[CF_OVF1] = 1'b1;
        end
        // Baud pulse from counter 1 only, even without interrupts.
        baud_next = c1_wrap;
    end

    // Read data for the cycle after the read strobe.
    // Idle and unmapped reads give zero, so the bus sees no stale data.
    always_comb begin
        rdata_next = RESET_BYTE;
        if (RD) begin
            case (ADDR)
                OFS_C0_LOW:   rdata_next = c0_low_reg;
                OFS_C0_HIGH:  rdata_next = c0_high_reg;
                OFS_C1_LOW:   rdata_next = c1_low_reg;
                OFS_C1_HIGH:  rdata_next = c1_high_reg;
                OFS_MODE:     rdata_next = mode_reg;
                OFS_CONTROL:  rdata_next = ctrl_reg;
                OFS_CORE_CFG: rdata_next = {7'h00, cfg_fast_reg};
                default:      rdata_next = RESET_BYTE;
            endcase
        end
    end

    // State registers.
    // All state clears on reset, leaving both counters stopped in mode 0 as timers.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            c0_low_reg   <= RESET_BYTE;
            c0_high_reg  <= RESET_BYTE;
            c1_low_reg   <= RESET_BYTE;
            c1_high_reg  <= RESET_BYTE;
            mode_reg     <= RESET_BYTE;
            ctrl_reg     <= RESET_BYTE;
            cfg_fast_reg <= 1'b0;
            rdata_reg    <= RESET_BYTE;
            baud_reg     <= 1'b0;
        end else begin
            c0_low_reg   <= c0_low_next;
            c0_high_reg  <= c0_high_next;
            c1_low_reg   <= c1_low_next;
            c1_high_reg  <= c1_high_next;
            mode_reg     <= mode_next;
            ctrl_reg     <= ctrl_next;
            cfg_fast_reg <= cfg_fast_next;
            rdata_reg    <= rdata_next;
            baud_reg     <= baud_next;
        end
    end

    // Outputs.
    // Flags come straight from the control register, so pins and software agree.
    assign RDATA             = rdata_reg;
    assign COUNTER0_OVERFLOW = ctrl_reg[CF_OVF0];
    assign COUNTER1_OVERFLOW = ctrl_reg[CF_OVF1];
    assign BAUD_TICK         = baud_reg;
endmodule // dtc_timer
`default_nettype wire

// file: dv/dtc_checker.sv
// Concurrent checks on the ports of the dual timer block.
`timescale 1ns/1ns
`default_nettype none
module dtc_checker (
    // Clock and reset.
    input  wire logic                       CLK,
    input  wire logic                       RESETN,
    // Register port.
    input  wire logic [dtc_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [dtc_pkg::DATA_W-1:0] WDATA,
    input  wire logic                       WR,
    input  wire logic                       RD,
    input  wire logic [dtc_pkg::DATA_W-1:0] RDATA,
    // Service and status.
    input  wire logic                       SERVICE0_ACK,
    input  wire logic                       SERVICE1_ACK,
    input  wire logic                       COUNTER0_OVERFLOW,
    input  wire logic                       COUNTER1_OVERFLOW,
    input  wire logic                       BAUD_TICK
);
    import dtc_pkg::*;
    logic ctl_wr_q;
    logic ack0_q;
    logic ack1_q;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // Remembers last cycle's control writes and acknowledges, the only causes of a falling flag.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctl_wr_q <= 1'b0;
            ack0_q   <= 1'b0;
            ack1_q   <= 1'b0;
        end else begin
            ctl_wr_q <= WR && ADDR == OFS_CONTROL;
            ack0_q   <= SERVICE0_ACK;
            ack1_q   <= SERVICE1_ACK;
        end
    end
    // Register port steps.
    sequence s_rd_unmapped;
        RD && ADDR == OFS_ISR_ACK;
    endsequence
    sequence s_set0;
        WR && ADDR == OFS_CONTROL && WDATA[CF_OVF0] && !SERVICE0_ACK;
    endsequence
    sequence s_set1;
        WR && ADDR == OFS_CONTROL && WDATA[CF_OVF1] && !SERVICE1_ACK;
    endsequence
    // Read data, flags and baud pulses.
    a_rdata_idle_zero: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data not zero outside a read answer");
    a_unmapped_read_zero: assert property (s_rd_unmapped |=> RDATA == 8'h00)
        else $error("unmapped read returned nonzero data");
    a_soft_set_flag0: assert property (s_set0 |=> COUNTER0_OVERFLOW)
        else $error("software could not set flag 0");
    a_soft_set_flag1: assert property (s_set1 |=> COUNTER1_OVERFLOW)
        else $error("software could not set flag 1");
    a_ack_clear_flag0: assert property (SERVICE0_ACK && !WR |=> !COUNTER0_OVERFLOW)
        else $error("service entry left flag 0 set");
    a_fall_cause_flag0: assert property ($fell(COUNTER0_OVERFLOW) |-> ack0_q || ctl_wr_q)
        else $error("flag 0 fell without a cause");
    a_fall_cause_flag1: assert property ($fell(COUNTER1_OVERFLOW) |-> ack1_q || ctl_wr_q)
        else $error("flag 1 fell without a cause");
    a_baud_tick_spacing: assert property (BAUD_TICK |=> !BAUD_TICK [*5])
        else $error("baud pulses closer than one tick");
    a_reset_quiet_outputs: assert property ($rose(RESETN) |-> !COUNTER0_OVERFLOW && !COUNTER1_OVERFLOW && !BAUD_TICK)
        else $error("outputs active right after reset");
endmodule // dtc_checker
bind dtc_timer dtc_checker u_checker (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .SERVICE0_ACK(SERVICE0_ACK), .SERVICE1_ACK(SERVICE1_ACK),
    .COUNTER0_OVERFLOW(COUNTER0_OVERFLOW), .COUNTER1_OVERFLOW(COUNTER1_OVERFLOW), .BAUD_TICK(BAUD_TICK));
`default_nettype wire

// file: dv/dtc_pin_model.sv
// Model of the external count and gate sources of the dual timer.
`timescale 1ns/1ns
`default_nettype none
module dtc_pin_model #(
    parameter int HOLD = 30
) (
    // Clock.
    input  wire logic       clk,
    // Requests from the bench.
    input  wire logic [1:0] pulse_req,
    input  wire logic [1:0] gate_req,
    // Pins.
    output logic      [1:0] count_pin,
    output logic      [1:0] gate_pin
);
    int left [2] = '{0, 0};
    // A pulse holds low, then high, each for HOLD clocks, longer than a slow machine cycle.
    always @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if (left[i] == 0 && pulse_req[i]) left[i] <= 2 * HOLD;
            else if (left[i] > 0) left[i] <= left[i] - 1;
        end
    end
    // Count pins idle high; gate pins follow the requested level.
    always_comb begin
        for (int i = 0; i < 2; i++) count_pin[i] = !(left[i] > HOLD);
        gate_pin = gate_req;
    end
endmodule // dtc_pin_model
`default_nettype wire

// file: dv/tb_dual_timer_counter_four_mode.sv
// Self-checking bench for the dual four-mode timer/counter.
`timescale 1ns/1ns
`default_nettype none
module tb_dual_timer_counter_four_mode;
    import dtc_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [1:0] pulse = 2'h0;
    logic [1:0] gate = 2'h0;
    logic [1:0] ack = 2'h0;
    logic [7:0] rdata, d, v, a8;
    logic [1:0] cpin, gpin;
    logic       ovf0, ovf1, baud;
    int         miscompares = 0;
    int         checks_done = 0;
    int         nbaud = 0;
    int         n0;
    // Device and its pin sources.
    dtc_timer dut (.CLK(clk), .RESETN(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .COUNTER0_COUNT_PIN(cpin[0]), .COUNTER1_COUNT_PIN(cpin[1]), .COUNTER0_GATE_PIN(gpin[0]),
        .COUNTER1_GATE_PIN(gpin[1]), .SERVICE0_ACK(ack[0]), .SERVICE1_ACK(ack[1]),
        .COUNTER0_OVERFLOW(ovf0), .COUNTER1_OVERFLOW(ovf1), .BAUD_TICK(baud));
    dtc_pin_model pins (.clk(clk), .pulse_req(pulse), .gate_req(gate), .count_pin(cpin), .gate_pin(gpin));
    // Clock and baud pulse counter.
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) if (baud === 1'b1) nbaud <= nbaud + 1;
    // Comparisons and the closing report.
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask
    task automatic chk_range(input int got, input int lo, input int hi);
        checks_done++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask
    task automatic test_done();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Register port cycles; the strobe stands for one cycle.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk);
        addr <= a;
        wdata <= x;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 q = rdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        rd_reg(a, d);
        chk_byte(d, e);
    endtask
    // Waits a bounded time for an overflow flag.
    task automatic wait_flag(input int i);
        for (int n = 0; n <= 3000; n++) begin
            if ((i == 1 ? ovf1 : ovf0) === 1'b1) return;
            @(posedge clk);
            #1;
        end
        miscompares++;
        test_done();
    endtask
    task automatic ack_pulse(input logic [1:0] m);
        @(posedge clk);
        ack <= m;
        @(posedge clk);
        ack <= 2'h0;
        #1;
    endtask
    task automatic pin_pulse();
        @(posedge clk);
        pulse <= 2'h1;
        @(posedge clk);
        pulse <= 2'h0;
        repeat (70) @(posedge clk);
    endtask
    // Main sequence.
    initial begin
        void'($urandom(93456));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 8'h88; a <= 8'h8F; a++) rdc(8'(a), 8'h00);
        $display("test reset values done");
        repeat (8) begin
            a8 = OFS_C0_LOW + 8'($urandom_range(3));
            v = 8'($urandom);
            wr_reg(a8, v);
            rdc(a8, v);
        end
        $display("test byte access done");
        wr_reg(OFS_CORE_CFG, 8'h01);
        wr_reg(OFS_MODE, 8'h01);
        wr_reg(OFS_C0_LOW, 8'hFE);
        wr_reg(OFS_C0_HIGH, 8'hFF);
        wr_reg(OFS_CONTROL, 8'h10);
        wait_flag(0);
        wr_reg(OFS_CONTROL, 8'h20);
        rdc(OFS_C0_LOW, 8'h00);
        rdc(OFS_C0_HIGH, 8'h00);
        chk_range(nbaud, 0, 0);
        ack_pulse(2'h1);
        chk_bit(ovf0, 1'b0);
        $display("test sixteen bit wrap done");
        wr_reg(OFS_MODE, 8'h00);
        wr_reg(OFS_C0_LOW, 8'h3F);
        wr_reg(OFS_C0_HIGH, 8'hFF);
        wr_reg(OFS_CONTROL, 8'h10);
        wait_flag(0);
        wr_reg(OFS_CONTROL, 8'h00);
        rdc(OFS_C0_LOW, 8'h20);
        rdc(OFS_C0_HIGH, 8'h00);
        $display("test thirteen bit wrap done");
        v = 8'($urandom);
        wr_reg(OFS_MODE, 8'h02);
        wr_reg(OFS_C0_LOW, 8'hFF);
        wr_reg(OFS_C0_HIGH, v);
        wr_reg(OFS_CONTROL, 8'h10);
        wait_flag(0);
        wr_reg(OFS_CONTROL, 8'h00);
        rdc(OFS_C0_LOW, v);
        rdc(OFS_C0_HIGH, v);
        $display("test reload done");
        wr_reg(OFS_MODE, 8'h09);
        wr_reg(OFS_C0_LOW, 8'h00);
        wr_reg(OFS_CONTROL, 8'h10);
        repeat (60) @(posedge clk);
        rdc(OFS_C0_LOW, 8'h00);
        gate <= 2'h1;
        repeat (60) @(posedge clk);
        wr_reg(OFS_CONTROL, 8'h00);
        rd_reg(OFS_C0_LOW, d);
        chk_range(d, 8, 12);
        gate <= 2'h0;
        $display("test gate done");
        wr_reg(OFS_MODE, 8'h05);
        wr_reg(OFS_C0_LOW, 8'h00);
        wr_reg(OFS_CONTROL, 8'h10);
        repeat (3) pin_pulse();
        wr_reg(OFS_CONTROL, 8'h00);
        rdc(OFS_C0_LOW, 8'h03);
        $display("test pin count done");
        wr_reg(OFS_MODE, 8'h20);
        wr_reg(OFS_C1_HIGH, 8'hFF);
        wr_reg(OFS_C1_LOW, 8'hFF);
        wr_reg(OFS_CORE_CFG, 8'h00);
        wr_reg(OFS_CONTROL, 8'h40);
        n0 = nbaud;
        repeat (240) @(posedge clk);
        chk_range(nbaud - n0, 19, 21);
        wr_reg(OFS_CORE_CFG, 8'h01);
        n0 = nbaud;
        repeat (240) @(posedge clk);
        chk_range(nbaud - n0, 39, 41);
        wr_reg(OFS_CONTROL, 8'h80);
        ack_pulse(2'h2);
        chk_bit(ovf1, 1'b0);
        $display("test tick rate done");
        wr_reg(OFS_MODE, 8'h23);
        n0 = nbaud;
        repeat (120) @(posedge clk);
        chk_range(nbaud - n0, 19, 21);
        chk_bit(ovf1, 1'b0);
        wr_reg(OFS_MODE, 8'hA3);
        repeat (2) @(posedge clk);
        n0 = nbaud;
        repeat (60) @(posedge clk);
        chk_range(nbaud - n0, 0, 0);
        wr_reg(OFS_MODE, 8'h23);
        wr_reg(OFS_C0_LOW, 8'h00);
        wr_reg(OFS_C0_HIGH, 8'hFE);
        wr_reg(OFS_CONTROL, 8'h40);
        wait_flag(1);
        wr_reg(OFS_CONTROL, 8'h00);
        rdc(OFS_C0_HIGH, 8'h00);
        rdc(OFS_C0_LOW, 8'h00);
        $display("test split mode done");
        wr_reg(OFS_MODE, 8'h30);
        wr_reg(OFS_C1_LOW, 8'h55);
        wr_reg(OFS_CONTROL, 8'h40);
        n0 = nbaud;
        repeat (100) @(posedge clk);
        rdc(OFS_C1_LOW, 8'h55);
        chk_range(nbaud - n0, 0, 0);
        wr_reg(OFS_CONTROL, 8'hA0);
        chk_bit(ovf0 & ovf1, 1'b1);
        wr_reg(OFS_CONTROL, 8'h00);
        chk_bit(ovf0 | ovf1, 1'b0);
        $display("test halt and flags done");
        test_done();
    end
endmodule // tb_dual_timer_counter_four_mode
`default_nettype wire
